// *** src/upx_ports.v ***
// upper quasi-bidirectional ports, code fetch strobe and host-mode entry
// Summary of operation
// - high address port pins are bidirectional and a written one leaves a weak pull-up.
// - the high address byte is driven during external code fetch and wide data moves.
// - while carrying address, rising edges use the strong pull-up.
// - in host mode the high address port takes control and address bits from the host.
// - special function port pins are bidirectional; a written one releases the pin.
// - in host mode the special function port also takes host control and address bits.
// - bit 0 is serial receive input and bit 1 is serial transmit output.
// - bits 2 and 3 are the active-low external interrupt inputs zero and one.
// - bits 4 and 5 are the count inputs of timer zero and timer one.
// - bit 6 outputs the active-low data write strobe and bit 7 the read strobe.
// - the code fetch strobe stays high while executing from internal memory.
// - executing externally, the code fetch strobe pulses twice per machine cycle.
// - a machine cycle with an external data access drops one strobe pulse.
// - a strobe falling edge with reset held over twenty-one machine cycles enters host mode.
// - reset high for two machine cycles resets; otherwise normal operation follows.
`include "upx_regs.vh"
module upx_ports (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst_b,
	// device reset pin, active high
	input  wire       reset_pin,
	// core side
	input  wire       ext_exec,
	input  wire       ext_data_cycle,
	input  wire       ext_data_move_wide,
	input  wire       ext_data_wr,
	input  wire [7:0] data_pointer_reg,
	input  wire [7:0] pc_high,
	input  wire       hi_port_wr,
	input  wire [7:0] hi_port_wdata,
	input  wire       sf_port_wr,
	input  wire [7:0] sf_port_wdata,
	input  wire       serial_tx,
	output reg  [7:0] hi_port_rdata,
	output reg  [7:0] sf_port_rdata,
	output reg        serial_rx,
	output reg        ext_irq_zero_n,
	output reg        ext_irq_one_n,
	output reg        timer_zero_count_in,
	output reg        timer_one_count_in,
	output reg  [7:0] host_hi_bits,
	output reg  [7:0] host_sf_bits,
	output wire       host_mode,
	output wire       core_reset,
	output wire       mc_start,
	// high address port pins
	input  wire [7:0] high_address_port_i,
	output reg  [7:0] high_address_port_o,
	output reg  [7:0] high_address_port_oe,
	output reg  [7:0] high_address_port_strong,
	// special function port pins
	input  wire [7:0] special_function_port_i,
	output reg  [7:0] special_function_port_o,
	output reg  [7:0] special_function_port_oe,
	// code fetch strobe pin
	input  wire       code_fetch_strobe_i,
	output reg        code_fetch_strobe_n,
	output reg        code_fetch_strobe_oe
);
	// ***************************
	// state and declarations
	// ***************************
	reg  [7:0] hi_latch_r;
	reg  [7:0] sf_latch_r;
	reg  [3:0] phase_r;
	reg  [3:0] phase_nxt;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg  [7:0] rst_mc_r;
	reg  [7:0] rst_mc_nxt;
	reg        data_cyc_r;
	reg        strobe_nxt;
	reg  [7:0] addr_byte;
	reg        code_fetch_strobe_n_prev_r;
	reg        wr_n_nxt;
	reg        rd_n_nxt;
	wire [7:0] hi_sync;
	wire [7:0] sf_sync;
	wire [1:0] ctl_sync;
	wire       rst_sync;
	wire       code_fetch_strobe_n_sync;

	// ***************************
	// pin synchronisers
	// ***************************
	upx_sync #(.W(8)) u_sync_hi (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  (high_address_port_i),
		.pin_out (hi_sync)
	);
	upx_sync #(.W(8)) u_sync_sf (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  (special_function_port_i),
		.pin_out (sf_sync)
	);
	upx_sync #(.W(2)) u_sync_ctl (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  ({code_fetch_strobe_i, reset_pin}),
		.pin_out (ctl_sync)
	);
	assign rst_sync  = ctl_sync[0];
	assign code_fetch_strobe_n_sync = ctl_sync[1];

	// ***************************
	// machine cycle phase
	// ***************************
	function [3:0] upx_phase_inc;
		input [3:0] ph;
		begin
			if (ph == `UPX_MC_LAST) begin
				upx_phase_inc = 4'h0;
			end else begin
				upx_phase_inc = ph + 4'h1;
			end
		end
	endfunction

	always @* begin
		phase_nxt = upx_phase_inc(phase_r);
	end
	assign mc_start = (phase_r == `UPX_PH_S1);

	// ***************************
	// reset and host mode control
	// ***************************
	assign host_mode  = (state_r == `UPX_ST_HOST);
	assign core_reset = (state_r == `UPX_ST_RESET);

	always @* begin
		state_nxt  = state_r;
		rst_mc_nxt = rst_mc_r;
		if (!rst_sync) begin
			rst_mc_nxt = 8'h00;
		end else if (mc_start && rst_mc_r != 8'hff) begin
			rst_mc_nxt = rst_mc_r + 8'h01;
		end
		case (state_r)
			`UPX_ST_RESET: begin
				// reset held for more than twenty-one machine cycles plus falling strobe
				if (rst_sync && code_fetch_strobe_n_prev_r && !code_fetch_strobe_n_sync && rst_mc_r > `UPX_HOST_MC) begin
					state_nxt = `UPX_ST_HOST;
				end else if (!rst_sync) begin
					state_nxt = `UPX_ST_NORMAL;
				end
			end
			`UPX_ST_NORMAL: begin
				if (rst_sync && rst_mc_r >= `UPX_RST_MC) begin
					state_nxt = `UPX_ST_RESET;
				end
			end
			`UPX_ST_HOST: begin
				// host mode left only when the reset pin is released, back through reset
				if (!rst_sync) begin
					state_nxt = `UPX_ST_RESET;
				end
			end
			default: begin
				state_nxt = `UPX_ST_RESET;
			end
		endcase
	end

	// ***************************
	// code fetch strobe cadence
	// ***************************
	always @* begin
		strobe_nxt = 1'b1;
		if (state_r == `UPX_ST_NORMAL && ext_exec) begin
			if (phase_nxt == `UPX_PH_S1 || phase_nxt == `UPX_PH_S1_END) begin
				strobe_nxt = 1'b0;
			end
			if ((phase_nxt == `UPX_PH_S4 || phase_nxt == `UPX_PH_S4_END) && !data_cyc_r) begin
				strobe_nxt = 1'b0;
			end
		end
	end

	// ***************************
	// pin output selection
	// ***************************
	function upx_data_strobe_n;
		input cyc;
		input want_wr;
		input is_wr;
		input first_ph;
		begin
			// held high in phase 0 so the address settles before the strobe
			upx_data_strobe_n = !(cyc && (is_wr == want_wr) && !first_ph);
		end
	endfunction

	always @* begin
		addr_byte = ext_data_move_wide ? data_pointer_reg : pc_high;
		wr_n_nxt  = upx_data_strobe_n(ext_data_cycle, 1'b1, ext_data_wr, mc_start);
		rd_n_nxt  = upx_data_strobe_n(ext_data_cycle, 1'b0, ext_data_wr, mc_start);
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_r                  <= 4'h0;
			state_r                  <= `UPX_ST_RESET;
			rst_mc_r                 <= 8'h00;
			hi_latch_r               <= `UPX_PORT_RST;
			sf_latch_r               <= `UPX_PORT_RST;
			data_cyc_r               <= 1'b0;
			code_fetch_strobe_n_prev_r              <= 1'b1;
			code_fetch_strobe_n      <= 1'b1;
			code_fetch_strobe_oe     <= 1'b0;
			high_address_port_o      <= `UPX_PORT_RST;
			high_address_port_oe     <= 8'h00;
			high_address_port_strong <= 8'h00;
		end else begin
			phase_r     <= phase_nxt;
			state_r     <= state_nxt;
			rst_mc_r    <= rst_mc_nxt;
			code_fetch_strobe_n_prev_r <= code_fetch_strobe_n_sync;
			if (core_reset) begin
				hi_latch_r <= `UPX_PORT_RST;
				sf_latch_r <= `UPX_PORT_RST;
			end else begin
				if (hi_port_wr) begin
					hi_latch_r <= hi_port_wdata;
				end
				if (sf_port_wr) begin
					sf_latch_r <= sf_port_wdata;
				end
			end
			if (mc_start) begin
				data_cyc_r <= ext_data_cycle;
			end
			// strobe pin released in reset and host mode so host can drive it
			code_fetch_strobe_n  <= strobe_nxt;
			code_fetch_strobe_oe <= (state_r == `UPX_ST_NORMAL);
			if (host_mode) begin
				high_address_port_o  <= `UPX_PORT_RST;
				high_address_port_oe <= 8'h00;
				high_address_port_strong <= 8'h00;
			end else if (state_r == `UPX_ST_NORMAL && (ext_exec || ext_data_move_wide)) begin
				high_address_port_o  <= addr_byte;
				// strong pull-up only for the one clock of a rising transition
				high_address_port_oe <= ~addr_byte | (addr_byte & ~high_address_port_o);
				high_address_port_strong <= addr_byte & ~high_address_port_o;
			end else begin
				// quasi-bidirectional: only zeros drive, ones rest on the weak pull-up
				high_address_port_o  <= hi_latch_r;
				high_address_port_oe <= ~hi_latch_r;
				high_address_port_strong <= 8'h00;
			end
		end
	end

	// ***************************
	// special function port drive
	// ***************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			special_function_port_o  <= `UPX_PORT_RST;
			special_function_port_oe <= 8'h00;
		end else begin
			if (host_mode) begin
				special_function_port_o  <= `UPX_PORT_RST;
				special_function_port_oe <= 8'h00;
			end else begin
				special_function_port_o  <= sf_latch_r;
				special_function_port_o[`UPX_BIT_TXD] <= sf_latch_r[`UPX_BIT_TXD] & serial_tx;
				special_function_port_o[`UPX_BIT_WR]  <= sf_latch_r[`UPX_BIT_WR] & wr_n_nxt;
				special_function_port_o[`UPX_BIT_RD]  <= sf_latch_r[`UPX_BIT_RD] & rd_n_nxt;
				special_function_port_oe <= ~sf_latch_r;
				special_function_port_oe[`UPX_BIT_TXD] <= ~(sf_latch_r[`UPX_BIT_TXD] & serial_tx);
				special_function_port_oe[`UPX_BIT_WR]  <= ~(sf_latch_r[`UPX_BIT_WR] & wr_n_nxt);
				special_function_port_oe[`UPX_BIT_RD]  <= ~(sf_latch_r[`UPX_BIT_RD] & rd_n_nxt);
			end
		end
	end

	// ***************************
	// pin input capture
	// ***************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hi_port_rdata       <= `UPX_PORT_RST;
			sf_port_rdata       <= `UPX_PORT_RST;
			serial_rx           <= 1'b1;
			ext_irq_zero_n      <= 1'b1;
			ext_irq_one_n       <= 1'b1;
			timer_zero_count_in <= 1'b1;
			timer_one_count_in  <= 1'b1;
			host_hi_bits        <= 8'h00;
			host_sf_bits        <= 8'h00;
		end else begin
			hi_port_rdata       <= hi_sync;
			sf_port_rdata       <= sf_sync;
			serial_rx           <= sf_sync[`UPX_BIT_RXD];
			ext_irq_zero_n      <= sf_sync[`UPX_BIT_IRQ0];
			ext_irq_one_n       <= sf_sync[`UPX_BIT_IRQ1];
			timer_zero_count_in <= sf_sync[`UPX_BIT_T0];
			timer_one_count_in  <= sf_sync[`UPX_BIT_T1];
			if (host_mode) begin
				host_hi_bits <= hi_sync;
				host_sf_bits <= sf_sync;
			end
		end
	end
endmodule

// *** src/upx_regs.vh ***
// constants for the upper port and strobe block
`ifndef UPX_REGS_VH
`define UPX_REGS_VH
`define UPX_PORT_RST      8'hff
`define UPX_MC_LEN        4'h6
`define UPX_MC_LAST       4'h5
`define UPX_PH_S1         4'h0
`define UPX_PH_S1_END     4'h1
`define UPX_PH_S4         4'h3
`define UPX_PH_S4_END     4'h4
`define UPX_RST_MC        8'h02
`define UPX_HOST_MC       8'h15
`define UPX_BIT_RXD       0
`define UPX_BIT_TXD       1
`define UPX_BIT_IRQ0      2
`define UPX_BIT_IRQ1      3
`define UPX_BIT_T0        4
`define UPX_BIT_T1        5
`define UPX_BIT_WR        6
`define UPX_BIT_RD        7
`define UPX_ST_RESET      2'h0
`define UPX_ST_NORMAL     2'h1
`define UPX_ST_HOST       2'h2
`endif

// *** src/upx_sync.v ***
// three-stage synchroniser with agreement filter for pin inputs
module upx_sync #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         rst_b,
	// pins
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] pin_out
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	// first stage read only by second; change counts once s2 and s3 agree
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_r    <= {W{1'b1}};
			s2_r    <= {W{1'b1}};
			s3_r    <= {W{1'b1}};
			pin_out <= {W{1'b1}};
		end else begin
			s1_r    <= pin_in;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			pin_out <= (s2_r & s3_r) | (pin_out & (s2_r ^ s3_r));
		end
	end
endmodule

// *** testbench/upebp_chk.sv ***
// assertion checker for the upper port and fetch strobe block
module upebp_chk (
	// clock and reset
	input logic       clk_sys,
	input logic       rst_b,
	// core side
	input logic       reset_pin,
	input logic       ext_exec,
	input logic       ext_data_cycle,
	input logic       ext_data_move_wide,
	input logic [7:0] data_pointer_reg,
	input logic       core_reset,
	input logic       host_mode,
	// pins
	input logic [7:0] high_address_port_o,
	input logic [7:0] high_address_port_oe,
	input logic [7:0] high_address_port_strong,
	input logic [7:0] special_function_port_oe,
	input logic       code_fetch_strobe_n
);
	logic [7:0] hi_cnt_r;
	logic [7:0] hi_cnt_nxt;
	wire        run = !core_reset && !host_mode;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// raw reset pin high time, saturating
	assign hi_cnt_nxt = !reset_pin ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hff};
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) hi_cnt_r <= 8'h00;
		else hi_cnt_r <= hi_cnt_nxt;
	end
	// ****
	// properties
	// ****
	property p_idle; $rose(rst_b) |-> high_address_port_o == 8'hff && high_address_port_oe == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("port not idle after reset");
	property p_wide; (run && ext_data_move_wide && $stable(data_pointer_reg))[*3]
		|-> high_address_port_o == data_pointer_reg; endproperty
	a_wide: assert property (p_wide) else $error("pointer byte not on port");
	property p_strong; (run && ext_exec)[*3] |-> high_address_port_strong ==
		(high_address_port_o & ~$past(high_address_port_o)); endproperty
	a_strong: assert property (p_strong) else $error("strong pull-up mismatch");
	property p_drive; (run && ext_exec)[*3] |-> high_address_port_oe ==
		(~high_address_port_o | high_address_port_strong); endproperty
	a_drive: assert property (p_drive) else $error("address drive mismatch");
	property p_free; host_mode[*3] |-> (high_address_port_oe | special_function_port_oe) == 8'h00;
	endproperty
	a_free: assert property (p_free) else $error("port driven in host mode");
	property p_quiet; (run && !ext_exec)[*2] |-> code_fetch_strobe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("strobe active on internal run");
	property p_two; (run && ext_exec && !ext_data_cycle)[*8] ##0 $fell(code_fetch_strobe_n)
		|-> ##3 $fell(code_fetch_strobe_n); endproperty
	a_two: assert property (p_two) else $error("strobe pulse missing");
	property p_one; (run && ext_exec && ext_data_cycle)[*8] ##0 $fell(code_fetch_strobe_n)
		|-> ##1 (!$fell(code_fetch_strobe_n))[*5]; endproperty
	a_one: assert property (p_one) else $error("strobe pulse not dropped");
	property p_rst; hi_cnt_r == 8'h1e |-> core_reset || host_mode; endproperty
	a_rst: assert property (p_rst) else $error("reset pin ignored");
	property p_host; $rose(host_mode) |-> hi_cnt_r > 8'h78; endproperty
	a_host: assert property (p_host) else $error("host mode entered early");
	c_host: cover property ($rose(host_mode));
	c_run: cover property ($fell(core_reset));
	c_data: cover property (run && ext_data_cycle && $fell(code_fetch_strobe_n));
endmodule

// *** testbench/upebp_pins.sv ***
// far side pins: external memory or programming host
module upebp_pins (
	// design side
	input  logic [7:0] hi_o,
	input  logic [7:0] hi_oe,
	input  logic [7:0] sf_o,
	input  logic [7:0] sf_oe,
	input  logic       ps_o,
	input  logic       ps_oe,
	// far side pulls low where set
	input  logic [7:0] hi_low,
	input  logic [7:0] sf_low,
	input  logic       ps_low,
	// wire levels
	output logic [7:0] hi_i,
	output logic [7:0] sf_i,
	output logic       ps_i
);
	// weak pull-up wins only when nobody pulls low
	assign hi_i = ~hi_low & (~hi_oe | hi_o);
	assign sf_i = ~sf_low & (~sf_oe | sf_o);
	// host forces the falling edge itself
	assign ps_i = ~ps_low & (~ps_oe | ps_o);
endmodule

// *** testbench/upper_ports_ext_bus_pins_bench.sv ***
// self-checking bench for the upper port and fetch strobe block
module upper_ports_ext_bus_pins_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys, rst_b, reset_pin, ext_exec, ext_data_cycle, ext_data_move_wide;
	logic       ext_data_wr, hi_port_wr, sf_port_wr, serial_tx, serial_rx, ext_irq_zero_n;
	logic       ext_irq_one_n, timer_zero_count_in, timer_one_count_in, host_mode;
	logic       core_reset, code_fetch_strobe_n, code_fetch_strobe_oe, code_fetch_strobe_i;
	logic       ps_low, mc_start;
	logic [7:0] data_pointer_reg, pc_high, hi_port_wdata, sf_port_wdata, hi_low, sf_low, lo;
	logic [7:0] hi_port_rdata, sf_port_rdata, host_hi_bits, host_sf_bits;
	logic [7:0] high_address_port_i, high_address_port_o, high_address_port_oe;
	logic [7:0] high_address_port_strong, special_function_port_i;
	logic [7:0] special_function_port_o, special_function_port_oe;
	int         num_errors, total_checks, n;
	upx_ports i_upx_ports (.clk_sys, .rst_b, .reset_pin, .ext_exec, .ext_data_cycle,
		.ext_data_move_wide, .ext_data_wr, .data_pointer_reg, .pc_high, .hi_port_wr,
		.hi_port_wdata, .sf_port_wr, .sf_port_wdata, .serial_tx, .hi_port_rdata,
		.sf_port_rdata, .serial_rx, .ext_irq_zero_n, .ext_irq_one_n, .timer_zero_count_in,
		.timer_one_count_in, .host_hi_bits, .host_sf_bits, .host_mode, .core_reset,
		.mc_start, .high_address_port_i, .high_address_port_o, .high_address_port_oe,
		.high_address_port_strong, .special_function_port_i, .special_function_port_o,
		.special_function_port_oe, .code_fetch_strobe_i, .code_fetch_strobe_n,
		.code_fetch_strobe_oe);
	upebp_pins i_upebp_pins (.hi_o(high_address_port_o), .hi_oe(high_address_port_oe),
		.sf_o(special_function_port_o), .sf_oe(special_function_port_oe),
		.ps_o(code_fetch_strobe_n), .ps_oe(code_fetch_strobe_oe), .hi_low, .sf_low, .ps_low,
		.hi_i(high_address_port_i), .sf_i(special_function_port_i), .ps_i(code_fetch_strobe_i));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ****
	// helpers
	// ****
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	task wr(input logic [7:0] hd, input logic [7:0] sd);
		{hi_port_wr, sf_port_wr, hi_port_wdata, sf_port_wdata} = {2'b11, hd, sd};
		cyc(1);
		{hi_port_wr, sf_port_wr} = 2'b00;
		cyc(3);
	endtask
	// fetch strobe falls over k cycles
	task falls(input int k, input logic [7:0] exp);
		logic p;
		n = 0;
		p = code_fetch_strobe_n;
		repeat (k) begin
			cyc(1);
			if (p && !code_fetch_strobe_n) n++;
			p = code_fetch_strobe_n;
		end
		chk(n[7:0], exp);
	endtask
	// ****
	// scenarios
	// ****
	task t_port;
		wr(8'h5a, 8'hc3);
		chk(high_address_port_oe, 8'ha5);
		chk(special_function_port_oe, 8'h3c);
		wr(8'hff, 8'hff);
		{hi_low, sf_low, serial_tx} = {8'h81, 8'h29, 1'b0};
		cyc(6);
		chk(hi_port_rdata, 8'h7e);
		chk(sf_port_rdata, 8'hd4);
		chk({3'h0, timer_one_count_in, timer_zero_count_in, ext_irq_one_n, ext_irq_zero_n, serial_rx}, 8'h0a);
		chk({7'h0, special_function_port_oe[1]}, 8'h01);
		{hi_low, sf_low, serial_tx} = {8'h00, 8'h00, 1'b1};
	endtask
	task t_exec;
		{pc_high, ext_exec} = {8'ha5, 1'b1};
		cyc(8);
		falls(12, 8'h04);
		chk(high_address_port_o, 8'ha5);
		// one machine cycle start per six clocks
		lo = 8'h00;
		repeat (12) begin
			cyc(1);
			lo = lo + {7'h0, mc_start};
		end
		chk(lo, 8'h02);
		ext_data_cycle = 1;
		for (int w = 1; w >= 0; w--) begin
			ext_data_wr = w[0];
			lo = 8'h00;
			cyc(8);
			repeat (6) begin
				cyc(1);
				lo = lo | (~special_function_port_o & 8'hc0);
			end
			chk(lo, w ? 8'h40 : 8'h80);
		end
		falls(12, 8'h02);
		{ext_data_cycle, ext_exec, ext_data_move_wide, data_pointer_reg} = {3'b001, 8'h3c};
		cyc(6);
		chk(high_address_port_o, 8'h3c);
		ext_data_move_wide = 0;
		cyc(4);
		falls(12, 8'h00);
	endtask
	task t_host;
		reset_pin = 1;
		cyc(30);
		chk({7'h0, core_reset}, 8'h01);
		chk({7'h0, code_fetch_strobe_oe}, 8'h00);
		ps_low = 1;
		cyc(6);
		chk({7'h0, host_mode}, 8'h00);
		ps_low = 0;
		cyc(150);
		{ps_low, hi_low, sf_low} = {1'b1, 8'h0f, 8'hf0};
		n = 0;
		while (!host_mode && n < 20) begin
			cyc(1);
			n++;
		end
		chk({7'h0, host_mode}, 8'h01);
		cyc(6);
		chk(host_hi_bits, 8'hf0);
		chk(host_sf_bits, 8'h0f);
		{reset_pin, ps_low, hi_low, sf_low} = '0;
		cyc(20);
		chk({6'h0, host_mode, core_reset}, 8'h00);
	endtask
	initial begin
		{ext_exec, ext_data_cycle, ext_data_move_wide, ext_data_wr, hi_port_wr, sf_port_wr} = '0;
		{data_pointer_reg, pc_high, hi_port_wdata, sf_port_wdata, hi_low, sf_low} = '0;
		{num_errors, total_checks, ps_low, reset_pin, rst_b, serial_tx} = 2'b01;
		cyc(6);
		rst_b = 1;
		chk(high_address_port_o, 8'hff);
		chk({7'h0, code_fetch_strobe_n}, 8'h01);
		// write lands while still in reset, so it must be ignored
		wr(8'h00, 8'h00);
		chk(high_address_port_oe, 8'h00);
		cyc(6);
		chk({7'h0, core_reset}, 8'h00);
		t_port;
		t_exec;
		t_host;
		final_report;
	end
	initial begin
		repeat (2000) @(posedge clk_sys);
		num_errors++;
		final_report;
	end
endmodule
bind upx_ports upebp_chk i_upebp_chk (.clk_sys, .rst_b, .reset_pin, .ext_exec, .ext_data_cycle,
	.ext_data_move_wide, .data_pointer_reg, .core_reset, .host_mode, .high_address_port_o,
	.high_address_port_oe, .high_address_port_strong, .special_function_port_oe,
	.code_fetch_strobe_n);
